//--- logic/acsd_pkg.sv
`default_nettype none
package acsd_pkg;

    // Command word layout
    localparam int WORD_W = 8;
    localparam int START_POS = 7;
    localparam int CH_MSB = 6;
    localparam int CH_LSB = 4;
    localparam int DIF_POS = 3;
    localparam int RNG_MSB = 2;
    localparam logic [3:0] OP_CONV_LOW = 4'h0;
    localparam logic [3:0] OP_MODE_LOW = 4'h8;

    // Channel configuration store
    localparam int CH_N = 8;
    localparam int CH_W = 3;
    localparam int CFG_W = 4;
    localparam logic [3:0] CFG_RESET = 4'h7;

    // Range codes
    localparam logic [2:0] RNG_SE_NEG_HALF = 3'h2;
    localparam logic [2:0] RNG_SE_POS_HALF = 3'h3;
    localparam logic [2:0] RNG_SE_NEG_FULL = 3'h5;
    localparam logic [2:0] RNG_SE_POS_FULL = 3'h6;
    localparam logic [2:0] RNG_DIF_HALF = 3'h1;
    localparam logic [2:0] RNG_DIF_FULL = 3'h4;
    localparam logic [2:0] RNG_DIF_DOUBLE = 3'h7;

    // Operating modes
    localparam logic [2:0] MODE_EXT_CLK = 3'h0;
    localparam logic [2:0] MODE_EXT_ACQ = 3'h1;
    localparam logic [2:0] MODE_INT_CLK = 3'h2;
    localparam logic [2:0] MODE_RESET = 3'h4;
    localparam logic [2:0] MODE_PART_PD = 3'h6;
    localparam logic [2:0] MODE_FULL_PD = 3'h7;
    localparam logic [2:0] MODE_RESET_VAL = 3'h0;

    // Result bits that must leave before a new start bit counts
    localparam int RES_W = 16;
    localparam int CNT_W = 5;
    localparam logic [4:0] THR_EXT_CLK = 5'h0D;
    localparam logic [4:0] THR_EXT_ACQ = 5'h09;
    localparam logic [4:0] THR_INT_CLK = 5'h0C;
    localparam logic [4:0] THR_ALL = 5'h10;
    localparam logic [4:0] OUT_LAST = 5'h0F;

    // Front-end sample and saturation limits
    localparam int SMP_W = 18;
    localparam logic signed [17:0] BIP_MAX = 18'sh07FFF;
    localparam logic signed [17:0] BIP_MIN = -18'sh08000;
    localparam logic signed [17:0] UNI_MAX = 18'sh0FFFF;
    localparam logic signed [17:0] UNI_MIN = -18'sh10000;
    localparam logic signed [17:0] ZERO_S = 18'sh00000;
    localparam logic [15:0] CODE_MAX = 16'hFFFF;
    localparam logic [15:0] CODE_MIN = 16'h0000;
    localparam logic [15:0] CODE_FLIP = 16'h8000;

    // Conversion timing
    localparam int CLK_MHZ = 50;
    localparam int CONV_TIME_NS = 4000;
    localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_W = 8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_CONV = 2'b10,
        ST_POST = 2'b11
    } acsd_state_e;

endpackage
`default_nettype wire

//--- logic/acsd_sync3.sv
`timescale 1ns/100ps
`default_nettype none
module acsd_sync3
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Crossing level
    input  wire logic d,
    output var  logic q
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic q_ff;

    // Level only moves once the last two stages agree
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            q_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff)
                q_ff <= s3_ff;
        end
    end

    assign q = q_ff;
endmodule
`default_nettype wire

//--- logic/acsd_cfg_mem.sv
`timescale 1ns/100ps
`default_nettype none
module acsd_cfg_mem
#(
    parameter int DEPTH = 8,
    parameter int AW = 3,
    parameter int W = 4,
    parameter logic [3:0] RESET_VAL = 4'h7
)
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Write side
    input  wire logic          clear,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // Read side
    input  wire logic [AW-1:0] rd_addr,
    output var  logic [W-1:0]  rd_data
);
    logic [W-1:0] mem_ff [DEPTH];
    logic [W-1:0] rd_ff;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_ff[i] <= RESET_VAL;
            rd_ff <= RESET_VAL;
        end
        else
        begin
            if (clear)
            begin
                for (int i = 0; i < DEPTH; i++)
                    mem_ff[i] <= RESET_VAL;
            end
            else if (wr_en)
                mem_ff[wr_addr] <= wr_data;
            rd_ff <= mem_ff[rd_addr];
        end
    end

    assign rd_data = rd_ff;
endmodule
`default_nettype wire

//--- logic/acsd_serial_cmd.sv
`timescale 1ns/100ps
`default_nettype none
module acsd_serial_cmd
    import acsd_pkg::*;
(
    // System clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Serial link
    input  wire logic                    sclk,
    input  wire logic                    cs_n,
    input  wire logic                    din,
    output var  logic                    dout,
    output var  logic                    dout_oe,
    output var  logic                    conversion_done_strobe,
    // Front-end sample
    input  wire logic signed [acsd_pkg::SMP_W-1:0] sample_value,
    // Front-end selection and power
    output var  logic [acsd_pkg::CH_W-1:0] sel_pos_channel,
    output var  logic                    sel_neg_is_ground,
    output var  logic                    sel_differential,
    output var  logic [2:0]              sel_range,
    output var  logic [2:0]              mode_number,
    output var  logic                    partial_power_down,
    output var  logic                    full_power_down
);
    import acsd_pkg::*;

    // ---------------- Link side, rising edge ----------------
    logic       in_act_ff;
    logic [2:0] in_cnt_ff;
    logic [5:0] in_sr_ff;
    logic [7:0] lnk_word_ff;
    logic       word_tgl_ff;
    logic       pend_ff;
    logic       ld_snap_ff;
    // Link side, falling edge
    logic [15:0] out_sr_ff;
    logic [4:0]  out_cnt_ff;
    logic        loaded_ff;
    logic        seen_ff;
    logic        ld_tgl_ff;
    logic        dout_ff;
    logic        dout_oe_ff;
    // System side
    logic [15:0] res_ff;
    logic [4:0]  thr_ff;
    logic        res_tgl_ff;

    wire sclk_n = ~sclk;
    wire res_lvl;
    wire out_busy = loaded_ff && (out_cnt_ff < thr_ff);
    wire start_ok = !pend_ff && !out_busy;
    wire word_done = in_act_ff && (in_cnt_ff == 3'h6);
    wire [7:0] word_asm = {1'b1, in_sr_ff[5:0], din};
    wire word_is_conv = (word_asm[3:0] == OP_CONV_LOW);
    wire load_now = (res_lvl != seen_ff);

    // Partial words die with the frame
    always_ff @(posedge sclk or posedge rst or posedge cs_n)
    begin
        if (rst || cs_n)
        begin
            in_act_ff <= 1'b0;
            in_cnt_ff <= 3'h0;
            in_sr_ff <= 6'h00;
        end
        else if (!in_act_ff)
        begin
            in_act_ff <= din && start_ok;
            in_cnt_ff <= 3'h0;
        end
        else
        begin
            in_sr_ff <= {in_sr_ff[4:0], din};
            in_cnt_ff <= in_cnt_ff + 3'h1;
            if (word_done)
                in_act_ff <= 1'b0;
        end
    end

    // Finished word is held while its toggle crosses over
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
        begin
            lnk_word_ff <= 8'h00;
            word_tgl_ff <= 1'b0;
            pend_ff <= 1'b0;
            ld_snap_ff <= 1'b0;
        end
        else if (word_done && !cs_n)
        begin
            lnk_word_ff <= word_asm;
            word_tgl_ff <= ~word_tgl_ff;
            if (word_is_conv)
            begin
                pend_ff <= 1'b1;
                ld_snap_ff <= ld_tgl_ff;
            end
        end
        else if (ld_tgl_ff != ld_snap_ff)
            pend_ff <= 1'b0;
    end

    acsd_sync3 u_res_sync
    (
        .clk (sclk_n),
        .rst (rst),
        .d   (res_tgl_ff),
        .q   (res_lvl)
    );

    // Result shift register; res_ff is stable once its toggle lands
    always_ff @(negedge sclk or posedge rst)
    begin
        if (rst)
        begin
            out_sr_ff <= 16'h0000;
            out_cnt_ff <= 5'h00;
            loaded_ff <= 1'b0;
            seen_ff <= 1'b0;
            ld_tgl_ff <= 1'b0;
        end
        else if (load_now)
        begin
            out_sr_ff <= res_ff;
            out_cnt_ff <= 5'h00;
            loaded_ff <= 1'b1;
            seen_ff <= res_lvl;
            ld_tgl_ff <= ~ld_tgl_ff;
        end
        else if (!cs_n && loaded_ff)
        begin
            out_sr_ff <= {out_sr_ff[14:0], 1'b0};
            out_cnt_ff <= out_cnt_ff + 5'h01;
            if (out_cnt_ff == OUT_LAST)
                loaded_ff <= 1'b0;
        end
    end

    // Pin released at once when select rises
    always_ff @(negedge sclk or posedge rst or posedge cs_n)
    begin
        if (rst || cs_n)
        begin
            dout_ff <= 1'b0;
            dout_oe_ff <= 1'b0;
        end
        else
        begin
            dout_oe_ff <= 1'b1;
            dout_ff <= loaded_ff && !load_now && out_sr_ff[15];
        end
    end

    assign dout = dout_ff;
    assign dout_oe = dout_oe_ff;

    // ---------------- System side ----------------
    acsd_state_e state_ff;
    acsd_state_e nxt_state;
    logic        word_seen_ff;
    logic [7:0]  conv_cnt_ff;
    logic [2:0]  mode_ff;
    logic        part_pd_ff;
    logic        full_pd_ff;
    logic        strobe_ff;
    logic [2:0]  conv_ch_ff;
    logic [2:0]  sel_pos_ff;
    logic        sel_gnd_ff;
    logic        sel_dif_ff;
    logic [2:0]  sel_rng_ff;
    logic [3:0]  cfg_rd;
    wire         word_lvl;

    acsd_sync3 u_word_sync
    (
        .clk (clk),
        .rst (rst),
        .d   (word_tgl_ff),
        .q   (word_lvl)
    );

    wire       word_stb = (word_lvl != word_seen_ff);
    wire [2:0] w_ch = lnk_word_ff[CH_MSB:CH_LSB];
    wire       w_dif = lnk_word_ff[DIF_POS];
    wire [2:0] w_rng = lnk_word_ff[RNG_MSB:0];
    wire       w_conv = (lnk_word_ff[3:0] == OP_CONV_LOW);
    wire       w_mode = (lnk_word_ff[3:0] == OP_MODE_LOW);
    wire       w_cfg = !w_conv && !w_mode;
    wire       dif_rng_ok = (w_rng == RNG_DIF_HALF)
                         || (w_rng == RNG_DIF_FULL)
                         || (w_rng == RNG_DIF_DOUBLE);
    // Odd pair codes leave every channel untouched
    wire       cfg_legal = !w_dif || (!w_ch[0] && dif_rng_ok);
    wire       cfg_wr = word_stb && w_cfg && cfg_legal;
    wire       mode_legal = (w_ch != 3'h3) && (w_ch != 3'h5);
    wire       mode_wr = word_stb && w_mode && mode_legal;
    wire       mode_rst = mode_wr && (w_ch == MODE_RESET);
    wire       conv_go = word_stb && w_conv && (state_ff == ST_IDLE);
    wire       powered_dn = part_pd_ff || full_pd_ff;
    wire       conv_end = (conv_cnt_ff == CONV_W'(CONV_CYCLES - 1));
    wire       strobe_set = (state_ff == ST_POST) && !powered_dn
                         && (mode_ff != MODE_EXT_CLK);
    wire [4:0] thr_mode = (mode_ff == MODE_EXT_CLK) ? THR_EXT_CLK :
                          (mode_ff == MODE_EXT_ACQ) ? THR_EXT_ACQ :
                          (mode_ff == MODE_INT_CLK) ? THR_INT_CLK :
                          THR_ALL;
    wire       rd_dif = cfg_rd[DIF_POS];
    // Pair selection follows the addressed channel's own stored byte
    wire [2:0] rd_pos = rd_dif ? {conv_ch_ff[2:1], 1'b0} : conv_ch_ff;

    acsd_cfg_mem
    #(
        .DEPTH     (CH_N),
        .AW        (CH_W),
        .W         (CFG_W),
        .RESET_VAL (CFG_RESET)
    )
    u_cfg
    (
        .clk     (clk),
        .rst     (rst),
        .clear   (mode_rst),
        .wr_en   (cfg_wr),
        .wr_addr (w_ch),
        .wr_data ({w_dif, w_rng}),
        .rd_addr (w_ch),
        .rd_data (cfg_rd)
    );

    // Clamp instead of wrapping; low bits already hold two's complement
    function automatic logic [15:0] sat_code
    (
        input logic signed [17:0] raw,
        input logic [2:0]         rng,
        input logic               dif
    );
        logic pos_uni;
        logic neg_uni;
        pos_uni = !dif && ((rng == RNG_SE_POS_HALF)
                        || (rng == RNG_SE_POS_FULL));
        neg_uni = !dif && ((rng == RNG_SE_NEG_HALF)
                        || (rng == RNG_SE_NEG_FULL));
        if (pos_uni)
            sat_code = (raw < ZERO_S) ? CODE_MIN :
                       (raw > UNI_MAX) ? CODE_MAX : raw[15:0];
        else if (neg_uni)
            sat_code = (raw < UNI_MIN) ? CODE_MIN :
                       (raw >= ZERO_S) ? CODE_MAX : raw[15:0];
        else
            sat_code = (raw < BIP_MIN) ? CODE_MIN :
                       (raw > BIP_MAX) ? CODE_MAX :
                       (raw[15:0] ^ CODE_FLIP);
    endfunction

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: if (conv_go) nxt_state = ST_READ;
            ST_READ: nxt_state = powered_dn ? ST_POST : ST_CONV;
            ST_CONV: if (conv_end) nxt_state = ST_POST;
            ST_POST: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= ST_IDLE;
            word_seen_ff <= 1'b0;
            conv_cnt_ff <= 8'h00;
            conv_ch_ff <= 3'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            word_seen_ff <= word_lvl;
            conv_cnt_ff <= (state_ff == ST_CONV) ? conv_cnt_ff + 8'h01
                                                 : 8'h00;
            if (conv_go)
                conv_ch_ff <= w_ch;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_ff <= MODE_RESET_VAL;
            part_pd_ff <= 1'b0;
            full_pd_ff <= 1'b0;
        end
        else if (mode_wr)
        begin
            mode_ff <= mode_rst ? MODE_RESET_VAL : w_ch;
            part_pd_ff <= (w_ch == MODE_PART_PD);
            full_pd_ff <= (w_ch == MODE_FULL_PD);
        end
    end

    // Front-end selection latched from the stored byte
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sel_pos_ff <= 3'h0;
            sel_gnd_ff <= 1'b1;
            sel_dif_ff <= 1'b0;
            sel_rng_ff <= CFG_RESET[2:0];
        end
        else if (state_ff == ST_READ)
        begin
            sel_pos_ff <= rd_pos;
            sel_gnd_ff <= !rd_dif;
            sel_dif_ff <= rd_dif;
            sel_rng_ff <= cfg_rd[2:0];
        end
    end

    // A new word clears the strobe, but a posting result wins
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            res_ff <= 16'h0000;
            thr_ff <= THR_ALL;
            res_tgl_ff <= 1'b0;
            strobe_ff <= 1'b0;
        end
        else
        begin
            if (state_ff == ST_CONV && conv_end)
                res_ff <= sat_code(sample_value, sel_rng_ff, sel_dif_ff);
            else if (state_ff == ST_READ && powered_dn)
                res_ff <= CODE_MIN;
            if (state_ff == ST_POST)
            begin
                thr_ff <= thr_mode;
                res_tgl_ff <= ~res_tgl_ff;
            end
            if (strobe_set)
                strobe_ff <= 1'b1;
            else if (word_stb)
                strobe_ff <= 1'b0;
        end
    end

    assign conversion_done_strobe = strobe_ff;
    assign sel_pos_channel = sel_pos_ff;
    assign sel_neg_is_ground = sel_gnd_ff;
    assign sel_differential = sel_dif_ff;
    assign sel_range = sel_rng_ff;
    assign mode_number = mode_ff;
    assign partial_power_down = part_pd_ff;
    assign full_power_down = full_pd_ff;

    // ---------------- Checks ----------------
    strobe_mode0_a: assert property (@(posedge clk) disable iff (rst)
        (mode_ff == MODE_EXT_CLK) |-> !strobe_ff)
        else $error("strobe high in external clock mode");
    strobe_set_a: assert property (@(posedge clk) disable iff (rst)
        strobe_set |=> strobe_ff [*1] ##0 $changed(res_tgl_ff))
        else $error("strobe not raised with posted result");
    cfg_reserved_a: assert property (@(posedge clk) disable iff (rst)
        (word_stb && w_cfg && w_dif && w_ch[0]) |=> $stable(u_cfg.mem_ff[w_ch]))
        else $error("reserved pair code changed configuration");
    conv_len_a: assert property (@(posedge clk) disable iff (rst)
        (state_ff == ST_READ && !powered_dn) |=> (state_ff == ST_CONV) [*8])
        else $error("conversion ended too early");
    pair_sel_a: assert property (@(posedge clk) disable iff (rst)
        sel_dif_ff |-> (!sel_pos_ff[0] && !sel_gnd_ff))
        else $error("differential pair not on even channel");
    single_gnd_a: assert property (@(posedge clk) disable iff (rst)
        !sel_dif_ff |-> sel_gnd_ff)
        else $error("single-ended input not against ground");
    sat_high_a: assert property (@(posedge clk) disable iff (rst)
        (state_ff == ST_CONV && conv_end && sample_value > UNI_MAX)
        |=> (res_ff == CODE_MAX))
        else $error("over-range sample not saturated");
    mode_pd_a: assert property (@(posedge clk) disable iff (rst)
        (mode_wr && w_ch == MODE_PART_PD) |=> (part_pd_ff && !full_pd_ff
        && mode_number == MODE_PART_PD))
        else $error("partial power-down not entered");
    start_block_a: assert property (@(posedge sclk) disable iff (rst || cs_n)
        (!in_act_ff && !start_ok) |=> !in_act_ff)
        else $error("start bit taken while result bits owed");
endmodule
`default_nettype wire

//--- testbench/acsd_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module acsd_master_model
(
    // Serial link
    output var  logic        sclk,
    output var  logic        cs_n,
    output var  logic        din,
    input  wire logic        dout,
    input  wire logic        dout_oe
);
    logic [23:0] rx;

    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
        rx   = 24'h000000;
    end

    // One frame, MSB first; bits captured at each rising edge
    task automatic xfer(input int n, input logic [23:0] tx);
        #7 cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            din = tx[i];
            #40 sclk = 1'b1;
            // Undriven line reads as the opposite of its last level
            rx = {rx[22:0], dout_oe ? dout : ~dout};
            #40 sclk = 1'b0;
        end
        #40 cs_n = 1'b1;
        // Released line must not look like a held bit
        din = ~din;
    endtask
endmodule
`default_nettype wire

//--- testbench/tb_acsd_serial_cmd.sv
`timescale 1ns/100ps
`default_nettype none
module tb_acsd_serial_cmd;
    import acsd_pkg::*;

    logic                    clk;
    logic                    rst;
    logic                    sclk;
    logic                    cs_n;
    logic                    din;
    logic                    dout;
    logic                    dout_oe;
    logic                    conversion_done_strobe;
    logic signed [SMP_W-1:0] sample_value;
    logic [CH_W-1:0]         sel_pos_channel;
    logic                    sel_neg_is_ground;
    logic                    sel_differential;
    logic [2:0]              sel_range;
    logic [2:0]              mode_number;
    logic                    partial_power_down;
    logic                    full_power_down;
    int                      error_cnt;
    int                      n_checks;
    logic [2:0]              mw [6] = '{3'h2, 3'h6, 3'h7, 3'h3, 3'h1, 3'h4};
    logic [2:0]              me [6] = '{3'h2, 3'h6, 3'h7, 3'h7, 3'h1, 3'h0};

    acsd_serial_cmd i_acsd_serial_cmd
    (
        .clk                    (clk),
        .rst                    (rst),
        .sclk                   (sclk),
        .cs_n                   (cs_n),
        .din                    (din),
        .dout                   (dout),
        .dout_oe                (dout_oe),
        .conversion_done_strobe (conversion_done_strobe),
        .sample_value           (sample_value),
        .sel_pos_channel        (sel_pos_channel),
        .sel_neg_is_ground      (sel_neg_is_ground),
        .sel_differential       (sel_differential),
        .sel_range              (sel_range),
        .mode_number            (mode_number),
        .partial_power_down     (partial_power_down),
        .full_power_down        (full_power_down)
    );

    acsd_master_model i_acsd_master_model
    (
        .sclk    (sclk),
        .cs_n    (cs_n),
        .din     (din),
        .dout    (dout),
        .dout_oe (dout_oe)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string what, input logic [23:0] exp,
                         input logic [23:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Word crossing needs a few system cycles after the frame
    task automatic cmd(input logic [7:0] w);
        i_acsd_master_model.xfer(8, {16'h0000, w});
        repeat (10) @(posedge clk);
    endtask

    task automatic wait_strobe;
        int n;
        n = 0;
        while (conversion_done_strobe !== 1'b1 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        check("strobe", 24'h000001, 24'(conversion_done_strobe));
    endtask

    // First sample undriven, then four sync falls and a load fall
    task automatic convert(input logic [7:0] cfg, input logic [7:0] start,
                           input logic signed [17:0] smp,
                           input logic [15:0] code, input logic [2:0] pos,
                           input logic dif, input logic [2:0] rng);
        logic [23:0] exp;
        exp = {1'b1, 5'h00, code, 2'b00};
        cmd(cfg);
        @(posedge clk);
        #2 sample_value = smp;
        cmd(start);
        check("sel", 24'({pos, dif, !dif, rng}),
              24'({sel_pos_channel, sel_differential, sel_neg_is_ground,
                   sel_range}));
        wait_strobe();
        i_acsd_master_model.xfer(24, 24'h000000);
        check("result", exp, i_acsd_master_model.rx);
    endtask

    initial
    begin
        #200000;
        error_cnt++;
        print_verdict();
    end

    initial
    begin
        error_cnt = 0;
        n_checks = 0;
        rst = 1'b1;
        sample_value = 18'sh00000;
        repeat (4) @(posedge clk);
        #2 rst = 1'b0;
        repeat (2) @(posedge clk);
        check("rst", 24'h00008E, 24'({sel_neg_is_ground, mode_number,
              sel_range, dout_oe}));
        for (int i = 0; i < 6; i++)
        begin
            cmd({1'b1, mw[i], OP_MODE_LOW});
            check("mode", 24'(me[i]), 24'(mode_number));
            check("pd", 24'({me[i] == 3'h6, me[i] == 3'h7}),
                  24'({partial_power_down, full_power_down}));
        end
        i_acsd_master_model.xfer(4, 24'h00000A);
        cmd(8'hA8);
        check("mode", 24'h000002, 24'(mode_number));
        check("release", 24'h000000, 24'({dout_oe, dout}));
        convert(8'hAC, 8'hA0, 18'sh01234, 16'h9234, 3'h2, 1'b1, 3'h4);
        convert(8'hD6, 8'hD0, 18'sh12345, 16'hFFFF, 3'h5, 1'b0, 3'h6);
        convert(8'hBF, 8'hB0, 18'sh1FFFF, 16'hFFFF, 3'h3, 1'b0, 3'h7);
        convert(8'h89, 8'h80, -18'sh00001, 16'h7FFF, 3'h0, 1'b1, 3'h1);
        convert(8'hEF, 8'hE0, 18'sh00000, 16'h8000, 3'h6, 1'b1, 3'h7);
        convert(8'h95, 8'h90, -18'sh00100, 16'hFF00, 3'h1, 1'b0, 3'h5);
        cmd(8'hD0);
        wait_strobe();
        cmd(8'h88);
        check("owed", 24'h000002, 24'(mode_number));
        i_acsd_master_model.xfer(24, 24'h000000);
        cmd(8'h88);
        check("mode", 24'h000000, 24'(mode_number));
        // External clock mode never raises the strobe
        cmd(8'hD0);
        repeat (250) @(posedge clk);
        check("strobe0", 24'h000000, 24'(conversion_done_strobe));
        print_verdict();
    end
endmodule
`default_nettype wire
